// ---- inc/iofr_cfg.svh ----
`ifndef IOFR_CFG_SVH
`define IOFR_CFG_SVH

// ----------------------------------------------------------------
// Register addresses (word index on the plain register port)
// ----------------------------------------------------------------
`define IOFR_ADDR_IN_SEL 6'h00
`define IOFR_ADDR_OUT_SEL 6'h10
`define IOFR_ADDR_CTRL 6'h20
`define IOFR_ADDR_STAT 6'h21
`define IOFR_CTRL_RESTORE_BIT 0
`define IOFR_STAT_REJECT_BIT 0

// ----------------------------------------------------------------
// Selection defaults and legal ranges (port numbers)
// ----------------------------------------------------------------
`define IOFR_IN_DEF_BASE 16'h0010
`define IOFR_OUT_DEF_BASE 16'h013c
`define IOFR_IN_NEG 16'hffff
`define IOFR_IN_LO1 16'h0010
`define IOFR_IN_HI1 16'h001f
`define IOFR_IN_LO2 16'h0030
`define IOFR_IN_HI2 16'h012b
`define IOFR_OUT_ZERO 16'h0000
`define IOFR_OUT_LO1 16'h013c
`define IOFR_OUT_HI1 16'h014b
`define IOFR_OUT_LO2 16'h015c
`define IOFR_OUT_HI2 16'h0257
`define IOFR_OUT_PORT0 10'h12c
`define IOFR_OUT_ZERO_OFS 9'h001

`endif

// ---- inc/iofr_pkg.sv ----
package iofr_pkg;
  // Stored selection: input side is two's complement, output side plain
  typedef logic [9:0] iofr_sel_type;
  typedef logic [8:0] iofr_idx_type;
endpackage

// ---- logic/iofr_remap.sv ----
`timescale 1ns/1ps
`include "iofr_cfg.svh"

module iofr_remap #(
  parameter int NUM_FUNC = 16,
  parameter int IN_PORTS = 300,
  parameter int OUT_PORTS = 300,
  parameter logic [15:0] IN_DEF_BASE = `IOFR_IN_DEF_BASE,
  parameter logic [15:0] OUT_DEF_BASE = `IOFR_OUT_DEF_BASE
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [5:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  input wire logic [IN_PORTS-1:0] inPins,
  output logic [OUT_PORTS-1:0] outPins,
  output logic [NUM_FUNC-1:0] funcIn,
  input wire logic [NUM_FUNC-1:0] funcOut
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic inLegal(input logic [15:0] d);
    inLegal = (d == `IOFR_IN_NEG) ||
              (d >= `IOFR_IN_LO1 && d <= `IOFR_IN_HI1) ||
              (d >= `IOFR_IN_LO2 && d <= `IOFR_IN_HI2);
  endfunction

  function automatic logic outLegal(input logic [15:0] d);
    outLegal = (d == `IOFR_OUT_ZERO) ||
               (d >= `IOFR_OUT_LO1 && d <= `IOFR_OUT_HI1) ||
               (d >= `IOFR_OUT_LO2 && d <= `IOFR_OUT_HI2);
  endfunction

  // Physical input index picked for function k
  function automatic iofr_pkg::iofr_idx_type inIdx(
      input int k, input iofr_pkg::iofr_sel_type sel);
    inIdx = sel[9] ? 9'(k) : sel[8:0];
  endfunction

  // Physical output index (port number minus first output port)
  function automatic iofr_pkg::iofr_idx_type outIdx(
      input int k, input iofr_pkg::iofr_sel_type sel);
    iofr_pkg::iofr_sel_type diff;
    diff = sel - `IOFR_OUT_PORT0;
    outIdx = (sel == 10'h000) ? 9'(k) + `IOFR_OUT_ZERO_OFS
                              : diff[8:0];
  endfunction

  // ----------------------------------------------------------------
  // Selection registers and register port
  // ----------------------------------------------------------------
  iofr_pkg::iofr_sel_type inSel_r [NUM_FUNC];
  iofr_pkg::iofr_sel_type inSel_nxt [NUM_FUNC];
  iofr_pkg::iofr_sel_type outSel_r [NUM_FUNC];
  iofr_pkg::iofr_sel_type outSel_nxt [NUM_FUNC];
  logic reject_r;
  logic reject_nxt;
  logic [15:0] rdData_r;
  logic [15:0] rdData_nxt;
  logic restore;

  assign restore = regWrite && regAddr == `IOFR_ADDR_CTRL &&
                   regWrData[`IOFR_CTRL_RESTORE_BIT];

  // Selection writes update one selection, a restore write all of them; refused values leave the old mapping
  always_comb begin
    reject_nxt = reject_r;
    rdData_nxt = 16'h0000;
    for (int k = 0; k < NUM_FUNC; k++) begin
      inSel_nxt[k] = inSel_r[k];
      outSel_nxt[k] = outSel_r[k];
      if (restore) begin
        inSel_nxt[k] = 10'(IN_DEF_BASE + 16'(k));
        outSel_nxt[k] = 10'(OUT_DEF_BASE + 16'(k));
      end
      if (regWrite && regAddr == `IOFR_ADDR_IN_SEL + 6'(k)) begin
        reject_nxt = !inLegal(regWrData);
        if (inLegal(regWrData)) begin
          inSel_nxt[k] = regWrData[9:0];
        end
      end
      if (regWrite && regAddr == `IOFR_ADDR_OUT_SEL + 6'(k)) begin
        reject_nxt = !outLegal(regWrData);
        if (outLegal(regWrData)) begin
          outSel_nxt[k] = regWrData[9:0];
        end
      end
      if (regRead && regAddr == `IOFR_ADDR_IN_SEL + 6'(k)) begin
        rdData_nxt = {{6{inSel_r[k][9]}}, inSel_r[k]}; // Sign extended
      end
      if (regRead && regAddr == `IOFR_ADDR_OUT_SEL + 6'(k)) begin
        rdData_nxt = {6'h00, outSel_r[k]};
      end
    end
    if (regRead && regAddr == `IOFR_ADDR_STAT) begin
      rdData_nxt[`IOFR_STAT_REJECT_BIT] = reject_r;
    end
  end

  // Reset loads the same defaults as a restore command
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int k = 0; k < NUM_FUNC; k++) begin
        inSel_r[k] <= 10'(IN_DEF_BASE + 16'(k));
        outSel_r[k] <= 10'(OUT_DEF_BASE + 16'(k));
      end
      reject_r <= 1'b0;
      rdData_r <= 16'h0000;
    end else begin
      inSel_r <= inSel_nxt;
      outSel_r <= outSel_nxt;
      reject_r <= reject_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdData = rdData_r;

  // ----------------------------------------------------------------
  // Pin synchronisers and routing
  // ----------------------------------------------------------------
  logic [IN_PORTS-1:0] sync1_r;
  logic [IN_PORTS-1:0] sync2_r;
  logic [NUM_FUNC-1:0] funcIn_r;
  logic [NUM_FUNC-1:0] funcIn_nxt;
  logic [OUT_PORTS-1:0] outPins_r;
  logic [OUT_PORTS-1:0] outPins_nxt;

  // Routing reads only the second stage; a port named by several
  // output functions carries their OR, which keeps it deterministic
  always_comb begin
    funcIn_nxt = '0;
    outPins_nxt = '0;
    for (int k = 0; k < NUM_FUNC; k++) begin
      funcIn_nxt[k] = sync2_r[inIdx(k, inSel_r[k])];
      if (funcOut[k]) begin
        outPins_nxt[outIdx(k, outSel_r[k])] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      funcIn_r <= '0;
      outPins_r <= '0;
    end else begin
      sync1_r <= inPins;
      sync2_r <= sync1_r;
      funcIn_r <= funcIn_nxt;
      outPins_r <= outPins_nxt;
    end
  end

  assign funcIn = funcIn_r;
  assign outPins = outPins_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_RESTORE_IN: assert property (
    restore |=> inSel_r[0] == 10'(IN_DEF_BASE) &&
      inSel_r[15] == 10'(IN_DEF_BASE + 16'h000f))
    else $error("input defaults not restored");
  AST_RESTORE_OUT: assert property (
    restore |=> outSel_r[0] == 10'(OUT_DEF_BASE) &&
      outSel_r[15] == 10'(OUT_DEF_BASE + 16'h000f))
    else $error("output defaults not restored");
  AST_IN_RANGE: assert property (
    inLegal({{6{inSel_r[3][9]}}, inSel_r[3]}))
    else $error("input selection out of range");
  AST_OUT_RANGE: assert property (
    outLegal({6'h00, outSel_r[3]}))
    else $error("output selection out of range");
  AST_IN_NEG: assert property (
    inSel_r[0][9] |=> funcIn[0] == $past(sync2_r[0]))
    else $error("negative selection did not use fixed port 0");
  AST_IN_MAP: assert property (
    (inSel_r[3] == 10'h030 && sync2_r[48]) |=> funcIn[3])
    else $error("input function not taken from selected port");
  AST_IN_NEG_K: assert property (
    inSel_r[2][9] |=> funcIn[2] == $past(sync2_r[2]))
    else $error("negative selection did not use fixed port 2");
  AST_OUT_ZERO: assert property (
    (outSel_r[0] == 10'h000 && funcOut[0]) |=> outPins[1])
    else $error("zero selection did not drive port 301");
  AST_OUT_ZERO_K: assert property (
    (outSel_r[15] == 10'h000 && funcOut[15]) |=> outPins[16])
    else $error("zero selection did not drive port 316");
  AST_OUT_MAP: assert property (
    (outSel_r[4] == 10'h15c && funcOut[4]) |=> outPins[48])
    else $error("output function not driven on port 348");
  AST_ACCEPT: assert property (
    (regWrite && regAddr == `IOFR_ADDR_IN_SEL && inLegal(regWrData))
      |=> inSel_r[0] == $past(regWrData[9:0]) && !reject_r)
    else $error("legal write not stored");
  AST_REJECT: assert property (
    (regWrite && regAddr == `IOFR_ADDR_IN_SEL + 6'h01 &&
      !inLegal(regWrData)) |=> $stable(inSel_r[1]) && reject_r)
    else $error("illegal write changed the mapping");
  AST_REJECT_OUT: assert property (
    (regWrite && regAddr == `IOFR_ADDR_OUT_SEL + 6'h01 &&
      !outLegal(regWrData)) |=> $stable(outSel_r[1]) && reject_r)
    else $error("illegal write changed the output mapping");

endmodule

// ---- tb/iofr_pins.sv ----
`timescale 1ns/1ps
// --------------------------------------------------
// Physical input board pins
// --------------------------------------------------
module iofr_pins (
  input wire logic clock,
  input wire logic [8:0] pinNum,
  input wire logic pinLvl,
  output logic [299:0] inPins
);
  // One pin at a time; the rest stay low, so a wrong route cannot hide
  always_ff @(posedge clock) begin
    inPins <= '0;
    inPins[pinNum] <= pinLvl;
  end
endmodule

// ---- tb/io_function_port_remap_test.sv ----
`timescale 1ns/1ps
`include "iofr_cfg.svh"
module io_function_port_remap_test;
  typedef struct packed {
    logic isOut;
    logic [3:0] k;
    logic [15:0] sel;
    logic [8:0] pin;
  } iofr_row_type;
  logic clock, rst, regWrite, regRead, pinLvl;
  logic [5:0] regAddr;
  logic [15:0] regWrData, regRdData, funcIn, funcOut;
  logic [8:0] pinNum;
  logic [299:0] inPins, outPins;
  int n_fail = 0;
  int samples_checked = 0;
  iofr_row_type r;
  // Selection, then the pin index that should carry function k
  iofr_row_type rows[9] = '{'{1'h0, 4'h0, 16'hffff, 9'h000},
    '{1'h0, 4'h2, 16'hffff, 9'h002}, '{1'h0, 4'h3, 16'h0030, 9'h030},
    '{1'h0, 4'hf, 16'h012b, 9'h12b}, '{1'h0, 4'h5, 16'h001f, 9'h01f},
    '{1'h1, 4'h0, 16'h0000, 9'h001}, '{1'h1, 4'hf, 16'h0000, 9'h010},
    '{1'h1, 4'h4, 16'h015c, 9'h030}, '{1'h1, 4'h7, 16'h0257, 9'h12b}};

  iofr_remap iofr_remap_i (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .inPins(inPins), .outPins(outPins),
    .funcIn(funcIn), .funcOut(funcOut));
  iofr_pins iofr_pins_i (.clock(clock), .pinNum(pinNum), .pinLvl(pinLvl),
    .inPins(inPins));

  // --------------------------------------------------
  // Helpers
  // --------------------------------------------------
  task automatic chk(string nm, logic [299:0] seen, logic [299:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [5:0] a, logic [15:0] d);
    @(posedge clock);
    regWrite <= 1'h1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [5:0] a, logic [15:0] e);
    @(posedge clock);
    regRead <= 1'h1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'h0;
    #1 chk("regRdData", regRdData, e);
  endtask
  task automatic bad(logic [5:0] a, logic [15:0] d, logic [15:0] keep);
    wr(a, d);
    rd(a, keep);
    rd(`IOFR_ADDR_STAT, 16'h0001);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Clock and a watchdog well past the under two hundred cycles needed
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end

  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial begin
    {rst, regWrite, regRead, pinLvl} = 4'h8;
    {regAddr, regWrData, funcOut, pinNum} = '0;
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    foreach (rows[i]) begin
      r = rows[i];
      wr({1'h0, r.isOut, r.k}, r.sel);
      rd({1'h0, r.isOut, r.k}, r.sel);
      rd(`IOFR_ADDR_STAT, 16'h0000);
      funcOut <= r.isOut ? 16'h0001 << r.k : 16'h0000;
      pinNum <= r.pin;
      pinLvl <= ~r.isOut;
      repeat (6) @(posedge clock);
      #1;
      if (r.isOut) chk("outPins", outPins, 300'h1 << r.pin);
      else chk("funcIn", funcIn, 16'h0001 << r.k);
      funcOut <= 16'h0000;
      pinLvl <= 1'h0;
    end
    // Out-of-range values must leave the stored route alone
    bad(6'h01, 16'h0020, 16'h0011);
    bad(6'h01, 16'hfffe, 16'h0011);
    bad(6'h11, 16'h014c, 16'h013d);
    bad(6'h11, 16'h0257 + 16'h0001, 16'h013d);
    rd(6'h3f, 16'h0000);
    wr(`IOFR_ADDR_CTRL, 16'h0001);
    rd(6'h00, 16'h0010);
    rd(6'h0f, 16'h001f);
    rd(6'h10, 16'h013c);
    rd(6'h1f, 16'h014b);
    pinNum <= 9'h01f;
    pinLvl <= 1'h1;
    funcOut <= 16'h8000;
    repeat (6) @(posedge clock);
    #1 chk("funcIn", funcIn, 16'h8000);
    chk("outPins", outPins, 300'h1 << 31);
    // Mid-run reset clears the outputs and brings back the defaults
    wr(6'h02, 16'h0030);
    rst <= 1'h1;
    repeat (3) @(posedge clock);
    #1 chk("outPins", outPins, 300'h0);
    chk("funcIn", funcIn, 16'h0000);
    chk("regRdData", regRdData, 16'h0000);
    @(posedge clock);
    rst <= 1'h0;
    rd(6'h02, 16'h0012);
    rd(6'h11, 16'h013d);
    rd(`IOFR_ADDR_STAT, 16'h0000);
    repeat (6) @(posedge clock);
    #1 chk("funcIn", funcIn, 16'h8000);
    chk("outPins", outPins, 300'h1 << 31);
    end_of_test();
  end
endmodule
